/* File: rtl/tacd_pkg.sv */
/*
  Package for the tag anticollision command decoder: command codes,
  state enumeration and the carriers for requests and answers.
  Assumes a frame receiver upstream that delivers decoded bytes and a
  CRC verdict, and a frame transmitter downstream that sends one byte.
*/
package tacd_pkg;

  // Command codes
  localparam logic [7:0] OP_PREFIX = 8'h06;
  localparam logic [7:0] OP_INV_START_ARG = 8'h00;
  localparam logic [7:0] OP_SLOT_POLL_ARG = 8'h04;
  localparam logic [3:0] OP_SLOT_CALL_LOW = 4'h6;
  localparam logic [7:0] OP_READ_BLOCK = 8'h08;
  localparam logic [7:0] OP_WRITE_BLOCK = 8'h09;
  localparam logic [7:0] OP_CHALLENGE = 8'h0a;
  localparam logic [7:0] OP_IDENTITY_READ = 8'h0b;
  localparam logic [7:0] OP_BACK_TO_CENSUS = 8'h0c;
  localparam logic [7:0] OP_CHOOSE_TAG = 8'h0e;
  localparam logic [7:0] OP_FINISH = 8'h0f;

  // Slot field layout inside the handle
  localparam int SLOT_LSB = 0;
  localparam int SLOT_W = 4;
  localparam logic [3:0] SLOT_ZERO = 4'h0;

  // Reset values
  localparam logic [7:0] HANDLE_RST = 8'h00;
  localparam logic [15:0] LFSR_SEED = 16'hace1;

  typedef enum logic [1:0] {
    TACD_READY,
    TACD_INVENTORY,
    TACD_CHOSEN
  } tacd_state_t;

  // One request frame as the receiver hands it over
  typedef struct packed {
    logic [7:0] code;
    logic [7:0] arg;
    logic has_arg;
    logic crc_ok;
  } tacd_req_t;

  // One answer byte request to the transmitter
  typedef struct packed {
    logic valid;
    logic [7:0] handle;
  } tacd_ans_t;

endpackage

/* File: rtl/tacd_decoder.sv */
/*
  Anticollision command decoder of a contactless memory tag.
  Takes complete request frames (code, optional argument, CRC verdict)
  as a one-cycle strobe on core_clk, keeps the tag state, the random
  handle and its slot index, and asks for a one-byte handle answer.
  Assumes the frame receiver runs on core_clk and that rst is raised
  whenever the tag leaves the field.
*/
`timescale 1ns/1ps
`default_nettype none

module tacd_decoder (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic req_strobe,
  input wire tacd_pkg::tacd_req_t req,
  input wire logic chosen_in,
  input wire logic back_to_census_in,
  output tacd_pkg::tacd_state_t tag_state,
  output logic [7:0] tag_handle,
  output tacd_pkg::tacd_ans_t answer,
  output logic other_cmd
);

  ////////////////////////////////////////////////////////////////////
  // Random source: free-running LFSR, advanced every cycle so the
  // draw depends on when the frame lands

  logic [15:0] lfsr;
  logic [15:0] next_lfsr;

  always_comb begin
    next_lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      lfsr <= tacd_pkg::LFSR_SEED;
    end else begin
      lfsr <= next_lfsr;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Command classification

  logic good;
  logic is_start;
  logic is_poll;
  logic is_call;
  logic [3:0] called_slot_number;

  always_comb begin
    good = req_strobe && req.crc_ok;
    called_slot_number = req.code[7:4];
    is_start = good && req.has_arg && req.code == tacd_pkg::OP_PREFIX
               && req.arg == tacd_pkg::OP_INV_START_ARG;
    is_poll = good && req.has_arg && req.code == tacd_pkg::OP_PREFIX
              && req.arg == tacd_pkg::OP_SLOT_POLL_ARG;
    // Slot zero belongs to the poll
    is_call = good && !req.has_arg
              && req.code[3:0] == tacd_pkg::OP_SLOT_CALL_LOW
              && called_slot_number != tacd_pkg::SLOT_ZERO;
  end

  ////////////////////////////////////////////////////////////////////
  // State, handle and answer

  tacd_pkg::tacd_state_t next_tag_state;
  logic [7:0] next_tag_handle;
  tacd_pkg::tacd_ans_t next_answer;
  logic next_other_cmd;

  always_comb begin
    next_tag_state = tag_state;
    next_tag_handle = tag_handle;
    next_answer = '0;
    next_answer.handle = tag_handle;
    next_other_cmd = 1'b0;
    if (is_start) begin
      if (tag_state == tacd_pkg::TACD_READY) begin
        next_tag_state = tacd_pkg::TACD_INVENTORY;
      end
      next_tag_handle = lfsr[7:0];
      next_answer.valid = 1'b1;
      next_answer.handle = lfsr[7:0];
    end else if (is_poll) begin
      if (tag_state == tacd_pkg::TACD_INVENTORY) begin
        next_tag_handle[tacd_pkg::SLOT_LSB +: tacd_pkg::SLOT_W] = lfsr[11:8];
        next_answer.valid = lfsr[11:8] == tacd_pkg::SLOT_ZERO;
        next_answer.handle = {tag_handle[7:4], lfsr[11:8]};
      end
    end else if (is_call) begin
      if (tag_state == tacd_pkg::TACD_INVENTORY
          && tag_handle[3:0] == called_slot_number) begin
        next_answer.valid = 1'b1;
      end
    end else if (good) begin
      if (tag_state == tacd_pkg::TACD_CHOSEN) begin
        next_other_cmd = 1'b1;
      end
    end
    // Handover from the select logic; census commands win the cycle
    if (!is_start && !is_poll && !is_call) begin
      if (chosen_in && tag_state == tacd_pkg::TACD_INVENTORY) begin
        next_tag_state = tacd_pkg::TACD_CHOSEN;
      end else if (back_to_census_in && tag_state == tacd_pkg::TACD_CHOSEN) begin
        next_tag_state = tacd_pkg::TACD_INVENTORY;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      tag_state <= tacd_pkg::TACD_READY;
      tag_handle <= tacd_pkg::HANDLE_RST;
      answer <= '0;
      other_cmd <= 1'b0;
    end else begin
      tag_state <= next_tag_state;
      tag_handle <= next_tag_handle;
      answer <= next_answer;
      other_cmd <= next_other_cmd;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Checks
  // Sampled rst in the antecedent keeps a one-edge reset from looking
  // like an unasked change of the handle or state

  property p_start_moves;
    @(posedge core_clk) disable iff (rst)
      is_start && tag_state == tacd_pkg::TACD_READY |=> tag_state == tacd_pkg::TACD_INVENTORY;
  endproperty
  a_start_moves: assert property (p_start_moves) else $error("start left ready tag");

  property p_start_answers;
    @(posedge core_clk) disable iff (rst)
      is_start |=> answer.valid && answer.handle == tag_handle;
  endproperty
  a_start_answers: assert property (p_start_answers) else $error("start not answered");

  property p_start_any_slot;
    @(posedge core_clk) disable iff (rst)
      is_start && tag_handle[3:0] != tacd_pkg::SLOT_ZERO |=> answer.valid;
  endproperty
  a_start_any_slot: assert property (p_start_any_slot) else $error("start used slot");

  property p_poll_ignored;
    @(posedge core_clk) disable iff (rst)
      !rst && is_poll && tag_state != tacd_pkg::TACD_INVENTORY
        |=> !answer.valid && $stable(tag_handle);
  endproperty
  a_poll_ignored: assert property (p_poll_ignored) else $error("poll acted outside inventory");

  property p_poll_upper_kept;
    @(posedge core_clk) disable iff (rst)
      !rst && is_poll |=> tag_handle[7:4] == $past(tag_handle[7:4]);
  endproperty
  a_poll_upper_kept: assert property (p_poll_upper_kept) else $error("poll touched upper");

  property p_handle_held;
    @(posedge core_clk) disable iff (rst)
      !rst && !is_start && !is_poll |=> $stable(tag_handle);
  endproperty
  a_handle_held: assert property (p_handle_held) else $error("handle changed unasked");

  property p_poll_zero;
    @(posedge core_clk) disable iff (rst)
      is_poll && tag_state == tacd_pkg::TACD_INVENTORY
        |=> answer.valid == (tag_handle[3:0] == tacd_pkg::SLOT_ZERO);
  endproperty
  a_poll_zero: assert property (p_poll_zero) else $error("poll answer wrong");

  property p_call_match;
    @(posedge core_clk) disable iff (rst)
      !rst && is_call |=> answer.valid == ($past(tag_state) == tacd_pkg::TACD_INVENTORY
                                   && tag_handle[3:0] == $past(called_slot_number));
  endproperty
  a_call_match: assert property (p_call_match) else $error("slot call answer wrong");

  property p_unchosen_quiet;
    @(posedge core_clk) disable iff (rst)
      good && !is_start && !is_poll && !is_call && tag_state != tacd_pkg::TACD_CHOSEN
        |=> !other_cmd && !answer.valid;
  endproperty
  a_unchosen_quiet: assert property (p_unchosen_quiet) else $error("unchosen tag acted");

  property p_chosen_other;
    @(posedge core_clk) disable iff (rst)
      !rst && good && !is_start && !is_poll && !is_call && tag_state == tacd_pkg::TACD_CHOSEN
        |=> other_cmd;
  endproperty
  a_chosen_other: assert property (p_chosen_other) else $error("chosen tag missed command");

  property p_bad_crc;
    @(posedge core_clk) disable iff (rst)
      !rst && req_strobe && !req.crc_ok && !chosen_in && !back_to_census_in
        |=> !answer.valid && !other_cmd && $stable(tag_state) && $stable(tag_handle);
  endproperty
  a_bad_crc: assert property (p_bad_crc) else $error("bad CRC frame acted");

endmodule
`default_nettype wire

/* File: verification/tacd_reader_model.sv */
/*
  Reader-side model: sends one request frame per call.
  Assumes the decoder samples req on core_clk with req_strobe.
*/
`timescale 1ns/1ps
`default_nettype none
module tacd_reader_model (
  input wire logic core_clk,
  output logic req_strobe,
  output tacd_pkg::tacd_req_t req
);
  initial begin
    req_strobe = 1'b0;
    req = '0;
  end
  // opcode framing
  // A released bus shows the inverse, not the last frame
  task automatic send(input logic [7:0] code, input logic [7:0] arg, input logic two,
                      input logic good);
    @(posedge core_clk);
    req_strobe <= 1'b1;
    req <= '{code, arg, two, good};
    @(posedge core_clk);
    req_strobe <= 1'b0;
    req <= '{~code, ~arg, ~two, ~good};
    #1;
  endtask
endmodule
`default_nettype wire

/* File: verification/tb.sv */
/*
  Testbench for the census decoder, with the reader model as far side.
  Assumes the decoder registers its answer on the taking edge itself.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic req_strobe;
  logic chosen_in = 1'b0;
  logic back_to_census_in = 1'b0;
  logic other_cmd;
  logic [7:0] tag_handle;
  tacd_pkg::tacd_req_t req;
  tacd_pkg::tacd_state_t tag_state;
  tacd_pkg::tacd_ans_t answer;
  int bad_count = 0;
  int total_checks = 0;
  always #2 core_clk = ~core_clk;
  tacd_reader_model tacd_reader_model_inst (.core_clk(core_clk), .req_strobe(req_strobe),
    .req(req));
  tacd_decoder tacd_decoder_inst (.core_clk(core_clk), .rst(rst), .req_strobe(req_strobe),
    .req(req), .chosen_in(chosen_in), .back_to_census_in(back_to_census_in),
    .tag_state(tag_state), .tag_handle(tag_handle), .answer(answer), .other_cmd(other_cmd));
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic pulse(input bit back);
    @(posedge core_clk);
    if (back) back_to_census_in <= 1'b1;
    else chosen_in <= 1'b1;
    @(posedge core_clk);
    back_to_census_in <= 1'b0;
    chosen_in <= 1'b0;
    #1;
  endtask
  task automatic st(input tacd_pkg::tacd_state_t exp);
    check("state", {6'h00, tag_state}, {6'h00, exp});
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_refused();
    tacd_reader_model_inst.send(8'h06, 8'h00, 1'b1, 1'b0);
    st(tacd_pkg::TACD_READY);
    check("bad crc answer", {7'h00, answer.valid}, 8'h00);
    tacd_reader_model_inst.send(8'h06, 8'h04, 1'b1, 1'b1);
    check("poll ready", {7'h00, answer.valid}, 8'h00);
    check("poll ready handle", tag_handle, 8'h00);
    tacd_reader_model_inst.send(8'h08, 8'h00, 1'b0, 1'b1);
    check("read ready", {7'h00, other_cmd}, 8'h00);
  endtask
  task automatic t_start();
    tacd_reader_model_inst.send(8'h06, 8'h00, 1'b1, 1'b1);
    st(tacd_pkg::TACD_INVENTORY);
    check("start valid", {7'h00, answer.valid}, 8'h01);
    check("start handle", answer.handle, tag_handle);
    @(posedge core_clk);
    #1;
    check("start drop", {7'h00, answer.valid}, 8'h00);
  endtask
  task automatic t_field_loss();
    @(posedge core_clk);
    rst <= 1'b1;
    @(posedge core_clk);
    rst <= 1'b0;
    #1;
    st(tacd_pkg::TACD_READY);
    check("loss handle", tag_handle, 8'h00);
    check("loss answer", {7'h00, answer.valid}, 8'h00);
  endtask
  // choose the lone answerer, then it must ignore census calls
  task automatic take(input logic [3:0] slot, output bit chosen);
    pulse(1'b0);
    chosen = 1;
    st(tacd_pkg::TACD_CHOSEN);
    tacd_reader_model_inst.send(8'h09, 8'h00, 1'b0, 1'b1);
    check("chosen other", {7'h00, other_cmd}, 8'h01);
    if (slot != 4'h0) begin
      tacd_reader_model_inst.send({slot, 4'h6}, 8'h00, 1'b0, 1'b1);
      check("chosen call", {7'h00, answer.valid}, 8'h00);
    end
  endtask
  // reader slot scan: a known handle is never chosen twice
  task automatic t_scan();
    logic [7:0] h;
    bit chosen;
    bit hit;
    h = tag_handle;
    chosen = 0;
    tacd_reader_model_inst.send(8'h06, 8'h04, 1'b1, 1'b0);
    check("bad crc poll", tag_handle, h);
    tacd_reader_model_inst.send(8'h06, 8'h04, 1'b1, 1'b1);
    check("poll upper", {4'h0, tag_handle[7:4]}, {4'h0, h[7:4]});
    h = tag_handle;
    hit = answer.valid === 1'b1;
    check("poll valid", {7'h00, answer.valid}, {7'h00, h[3:0] == 4'h0});
    if (hit) check("poll handle", answer.handle, h);
    // Single-byte call to slot zero belongs to the poll
    tacd_reader_model_inst.send(8'h06, 8'h00, 1'b0, 1'b1);
    check("call zero", {7'h00, answer.valid}, 8'h00);
    if (hit) take(h[3:0], chosen);
    for (int n = 1; n < 16; n++) begin
      tacd_reader_model_inst.send({4'(n), 4'h6}, 8'h00, 1'b0, 1'b1);
      check("call valid", {7'h00, answer.valid}, {7'h00, !chosen && h[3:0] == 4'(n)});
      check("slot held", tag_handle, h);
      if (answer.valid === 1'b1 && !chosen) begin
        check("call handle", answer.handle, h);
        take(h[3:0], chosen);
      end
    end
    if (chosen) pulse(1'b1);
    st(tacd_pkg::TACD_INVENTORY);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    #1;
    st(tacd_pkg::TACD_READY);
    check("reset handle", tag_handle, 8'h00);
    t_refused();
    t_start();
    for (int r = 0; r < 12; r++) t_scan();
    t_start();
    t_field_loss();
    t_start();
    summarize();
  end
  initial begin
    #40000;
    bad_count++;
    summarize();
  end
endmodule
`default_nettype wire
